// [pkg/rais_pkg.sv]
// constants and types shared by the reset and interrupt sequencer
package rais_pkg;
  // clock
  localparam int CLK_MHZ = 25;
  // timing, in oscillator clock periods unless noted
  localparam int FILTER_CLOCKS = 4;
  localparam int HOLD_CLOCKS = 18;
  localparam int FETCH_DELAY_CLOCKS = 6;
  localparam int POR_TIME_US = 5000;
  localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;
  // register indices; printed offsets are not word aligned
  localparam logic [7:0] IDX_RST_CAUSE = 8'hf7;
  localparam logic [7:0] IDX_SMR_SEL = 8'hf8;
  localparam logic [7:0] IDX_PRIO = 8'hf9;
  localparam logic [7:0] IDX_REQ = 8'hfa;
  localparam logic [7:0] IDX_MASK = 8'hfb;
  localparam logic [7:0] IDX_FLAGS = 8'hfc;
  localparam int AW = 10;
  localparam logic [AW-1:0] ADDR_RST_CAUSE = {IDX_RST_CAUSE, 2'b00};
  localparam logic [AW-1:0] ADDR_SMR_SEL = {IDX_SMR_SEL, 2'b00};
  localparam logic [AW-1:0] ADDR_PRIO = {IDX_PRIO, 2'b00};
  localparam logic [AW-1:0] ADDR_REQ = {IDX_REQ, 2'b00};
  localparam logic [AW-1:0] ADDR_MASK = {IDX_MASK, 2'b00};
  localparam logic [AW-1:0] ADDR_FLAGS = {IDX_FLAGS, 2'b00};
  // field positions
  localparam int REQ_EDGE_LO = 6;
  localparam int REQ_EDGE_HI = 7;
  localparam int MASK_GLOBAL = 7;
  localparam int N_IRQ = 5;
  localparam int IRQ_FIRST = 0;
  localparam int IRQ_SECOND = 1;
  localparam int IRQ_THIRD = 2;
  localparam int IRQ_TIMER0 = 3;
  localparam int IRQ_TIMER1 = 4;
  localparam int CAUSE_POR = 0;
  localparam int CAUSE_WDT = 1;
  localparam int CAUSE_STOP = 2;
  localparam int CAUSE_LVD = 3;
  localparam int CAUSE_EXT = 4;
  // reset values
  localparam logic [7:0] RST_REQ = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_PRIO = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_SMR = 8'h00;
  localparam logic [4:0] RST_CAUSE = 5'h01;
  // vectors
  localparam logic [15:0] RESET_VECTOR = 16'h000c;
  localparam logic [15:0] VEC_BASE = 16'h0000;

  typedef enum logic [1:0] {RS_POR, RS_HOLD, RS_WAIT, RS_RUN} rais_rst_st_t;
  typedef enum logic [2:0] {IS_IDLE, IS_PCL, IS_PCH, IS_FLG, IS_VHI, IS_VLO, IS_JUMP} rais_int_st_t;
endpackage

// [verilog/rais_sequencer.sv]
// reset sequencing, reset pin filter and vectored interrupt sequencer with apb registers
`timescale 1ns/10ps
`default_nettype none
module rais_sequencer #(
  parameter int POR_CYCLES = rais_pkg::POR_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [rais_pkg::AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic por_i,
  input wire logic wdt_timeout_i,
  input wire logic stop_recovery_i,
  input wire logic low_voltage_i,
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe_n_o,
  output logic reset_pullup_en_o,
  output logic core_reset_o,
  output logic data_strobe_n_o,
  output logic address_strobe_n_o,
  output logic fetch_start_o,
  output logic [15:0] fetch_addr_o,
  input wire logic port3_line1_i,
  input wire logic port3_line2_i,
  input wire logic port3_line3_i,
  input wire logic timer0_evt_i,
  input wire logic timer1_evt_i,
  input wire logic comparator_input_one_evt_i,
  input wire logic comparator_input_two_evt_i,
  input wire logic analog_mode_i,
  input wire logic [7:0] stop_recovery_src_i,
  input wire logic [15:0] pc_i,
  output logic push_valid_o,
  output logic [7:0] push_data_o,
  output logic vec_rd_o,
  output logic [15:0] vec_addr_o,
  input wire logic [7:0] prog_data_i,
  output logic jump_o,
  output logic [15:0] jump_addr_o
);
  localparam int CW = $clog2(POR_CYCLES + 1);
  localparam logic [CW-1:0] POR_LAST = CW'(POR_CYCLES - 1);
  localparam logic [CW-1:0] HOLD_LAST = CW'(rais_pkg::HOLD_CLOCKS - 1);
  localparam logic [CW-1:0] FETCH_LAST = CW'(rais_pkg::FETCH_DELAY_CLOCKS - 1);
  localparam logic [2:0] FILT = 3'(rais_pkg::FILTER_CLOCKS);

  if (POR_CYCLES < rais_pkg::HOLD_CLOCKS)
  begin : g_bad_por
    $error("POR_CYCLES must be at least the internal hold count");
  end

  typedef struct packed {
    rais_pkg::rais_rst_st_t rst_st;
    logic [CW-1:0] cnt;
    logic [2:0] low_cnt;
    logic pin_drive;
    logic core_rst;
    logic ds_n;
    logic as_n;
    logic fetch;
    logic [4:0] cause;
    logic [7:0] req;
    logic [7:0] mask;
    logic [7:0] prio;
    logic [7:0] flags;
    logic [7:0] stop_recovery_select;
    logic [2:0] prev_p;
    logic [7:0] prev_src;
    rais_pkg::rais_int_st_t int_st;
    logic [2:0] win;
    logic [15:0] pc;
    logic push_v;
    logic [7:0] push_d;
    logic vec_rd;
    logic [15:0] vec_addr;
    logic jump;
    logic [15:0] jump_addr;
    logic [7:0] rdata;
    logic pready;
    logic pslverr;
  } rais_state_t;

  rais_state_t s_q;
  rais_state_t s_d;

  // rotating priority: the start index from the priority register wins ties
  function automatic logic [2:0] rais_pick(input logic [4:0] pend, input logic [2:0] start);
    logic [2:0] res;
    logic found;
    logic [2:0] idx;
    logic [2:0] base;
    res = 3'h0;
    found = 1'b0;
    base = (start > 3'h4) ? 3'h0 : start;
    for (int i = 0; i < rais_pkg::N_IRQ; i++)
    begin
      idx = 3'((int'(base) + i) % rais_pkg::N_IRQ);
      if (!found && pend[idx])
      begin
        res = idx;
        found = 1'b1;
      end
    end
    return res;
  endfunction

  logic [4:0] evt;
  logic ext_det;
  logic grant;
  logic wr_acc;
  logic [2:0] win_c;

  always_comb
  begin
    logic [1:0] esel;
    logic [2:0] fall_p;
    logic [2:0] rise_p;
    logic [7:0] fall_src;
    esel = s_q.req[rais_pkg::REQ_EDGE_HI:rais_pkg::REQ_EDGE_LO];
    fall_p = 3'h0;
    rise_p = 3'h0;
    fall_src = 8'h00;
    s_d = s_q;
    /////////////////////////////////////////////////////////////////////////
    // apb slave: data latched in setup, answer in the access cycle
    s_d.pready = psel_i && !penable_i;
    s_d.pslverr = 1'b0;
    if (psel_i && !penable_i)
    begin
      s_d.rdata = 8'h00;
      if (paddr_i == rais_pkg::ADDR_REQ)
        s_d.rdata = s_q.req;
      else if (paddr_i == rais_pkg::ADDR_MASK)
        s_d.rdata = s_q.mask;
      else if (paddr_i == rais_pkg::ADDR_PRIO)
        s_d.rdata = s_q.prio;
      else if (paddr_i == rais_pkg::ADDR_FLAGS)
        s_d.rdata = s_q.flags;
      else if (paddr_i == rais_pkg::ADDR_SMR_SEL)
        s_d.rdata = s_q.stop_recovery_select;
      else if (paddr_i == rais_pkg::ADDR_RST_CAUSE)
        s_d.rdata = {3'h0, s_q.cause};
      else
        s_d.pslverr = 1'b1;
    end
    wr_acc = psel_i && penable_i && s_q.pready && pwrite_i;
    if (wr_acc)
    begin
      if (paddr_i == rais_pkg::ADDR_REQ)
        s_d.req = pwdata_i[7:0];
      else if (paddr_i == rais_pkg::ADDR_MASK)
        s_d.mask = pwdata_i[7:0];
      else if (paddr_i == rais_pkg::ADDR_PRIO)
        s_d.prio = pwdata_i[7:0];
      else if (paddr_i == rais_pkg::ADDR_FLAGS)
        s_d.flags = pwdata_i[7:0];
      else if (paddr_i == rais_pkg::ADDR_SMR_SEL)
        s_d.stop_recovery_select = pwdata_i[7:0];
      else if (paddr_i == rais_pkg::ADDR_RST_CAUSE)
        s_d.cause = s_q.cause & ~pwdata_i[4:0];
    end
    /////////////////////////////////////////////////////////////////////////
    // reset pin filter
    // our own drive reads back low, so it is not counted
    if (!reset_pin_i && !s_q.pin_drive)
      s_d.low_cnt = (s_q.low_cnt == FILT) ? FILT : 3'(s_q.low_cnt + 3'h1);
    else
      s_d.low_cnt = 3'h0;
    ext_det = (s_q.low_cnt == FILT);
    // cause bits are sticky, set wins over a software clear
    s_d.cause = s_d.cause | {ext_det, low_voltage_i, stop_recovery_i, wdt_timeout_i, por_i};
    // power-on or watchdog reset overrides every other state
    if (por_i || wdt_timeout_i)
    begin
      s_d.rst_st = rais_pkg::RS_POR;
      s_d.cnt = '0;
    end
    else if (s_q.rst_st != rais_pkg::RS_POR && (stop_recovery_i || low_voltage_i ||
             (ext_det && s_q.rst_st != rais_pkg::RS_HOLD)))
    begin
      // latched on the clock after four low samples
      s_d.rst_st = rais_pkg::RS_HOLD;
      s_d.cnt = '0;
    end
    else
    begin
      case (s_q.rst_st)
        rais_pkg::RS_POR:
        begin
          s_d.cnt = CW'(s_q.cnt + 1'b1);
          if (s_q.cnt == POR_LAST)
          begin
            s_d.rst_st = rais_pkg::RS_HOLD;
            s_d.cnt = '0;
          end
        end
        rais_pkg::RS_HOLD:
        begin
          // count 18, then wait for the pin to come high
          if (s_q.cnt != HOLD_LAST)
            s_d.cnt = CW'(s_q.cnt + 1'b1);
          else if (reset_pin_i)
          begin
            s_d.rst_st = rais_pkg::RS_WAIT;
            s_d.cnt = '0;
          end
        end
        rais_pkg::RS_WAIT:
        begin
          s_d.cnt = CW'(s_q.cnt + 1'b1);
          if (s_q.cnt == FETCH_LAST)
            s_d.rst_st = rais_pkg::RS_RUN;
        end
        default:
        begin
          s_d.cnt = '0;
        end
      endcase
    end
    // one pulse starts fetching at the reset vector
    s_d.fetch = (s_q.rst_st == rais_pkg::RS_WAIT) && (s_q.cnt == FETCH_LAST) &&
                (s_d.rst_st == rais_pkg::RS_RUN);
    // pin driven only for the power-on interval, which a watchdog timeout also starts
    s_d.pin_drive = (s_d.rst_st == rais_pkg::RS_POR);
    s_d.core_rst = (s_d.rst_st == rais_pkg::RS_POR) || (s_d.rst_st == rais_pkg::RS_HOLD);
    s_d.ds_n = !s_d.core_rst;
    s_d.as_n = s_d.core_rst ? !s_q.as_n : 1'b1;
    /////////////////////////////////////////////////////////////////////////
    // edge selection for the two port lines
    fall_p = s_q.prev_p & ~{port3_line3_i, port3_line2_i, port3_line1_i};
    rise_p = ~s_q.prev_p & {port3_line3_i, port3_line2_i, port3_line1_i};
    fall_src = s_q.prev_src & ~stop_recovery_src_i;
    s_d.prev_p = {port3_line3_i, port3_line2_i, port3_line1_i};
    s_d.prev_src = stop_recovery_src_i;
    // comparator events share the port line requests
    evt[rais_pkg::IRQ_THIRD] = fall_p[0] || (esel == 2'h3 && rise_p[0]) || comparator_input_one_evt_i;
    evt[rais_pkg::IRQ_FIRST] = (esel == 2'h1 ? rise_p[1] : fall_p[1]) || (esel == 2'h3 && rise_p[1]) ||
                               comparator_input_two_evt_i;
    // recovery sources on falling edge, joined by the port 3 line 3 falling edge
    evt[rais_pkg::IRQ_SECOND] = fall_p[2] || (analog_mode_i && |(fall_src & s_q.stop_recovery_select));
    evt[rais_pkg::IRQ_TIMER0] = timer0_evt_i;
    evt[rais_pkg::IRQ_TIMER1] = timer1_evt_i;
    /////////////////////////////////////////////////////////////////////////
    // global and per-source enables
    win_c = rais_pick(s_q.req[4:0] & s_q.mask[4:0], s_q.prio[2:0]);
    grant = (s_q.rst_st == rais_pkg::RS_RUN) && (s_q.int_st == rais_pkg::IS_IDLE) &&
            s_q.mask[rais_pkg::MASK_GLOBAL] && |(s_q.req[4:0] & s_q.mask[4:0]);
    s_d.push_v = 1'b0;
    s_d.vec_rd = 1'b0;
    s_d.jump = 1'b0;
    case (s_q.int_st)
      rais_pkg::IS_IDLE:
      begin
        if (grant)
        begin
          // disable, then save pc low, pc high, flags
          s_d.int_st = rais_pkg::IS_PCL;
          s_d.win = win_c;
          s_d.pc = pc_i;
          s_d.push_v = 1'b1;
          s_d.push_d = pc_i[7:0];
          s_d.mask[rais_pkg::MASK_GLOBAL] = 1'b0;
          s_d.req[win_c] = 1'b0;
        end
      end
      rais_pkg::IS_PCL:
      begin
        s_d.int_st = rais_pkg::IS_PCH;
        s_d.push_v = 1'b1;
        s_d.push_d = s_q.pc[15:8];
      end
      rais_pkg::IS_PCH:
      begin
        s_d.int_st = rais_pkg::IS_FLG;
        s_d.push_v = 1'b1;
        s_d.push_d = s_q.flags;
      end
      rais_pkg::IS_FLG:
      begin
        // high byte of the vector first
        s_d.int_st = rais_pkg::IS_VHI;
        s_d.vec_rd = 1'b1;
        s_d.vec_addr = rais_pkg::VEC_BASE | {12'h000, s_q.win, 1'b0};
      end
      rais_pkg::IS_VHI:
      begin
        s_d.int_st = rais_pkg::IS_VLO;
        s_d.jump_addr[15:8] = prog_data_i;
        s_d.vec_rd = 1'b1;
        s_d.vec_addr = rais_pkg::VEC_BASE | {12'h000, s_q.win, 1'b1};
      end
      rais_pkg::IS_VLO:
      begin
        s_d.int_st = rais_pkg::IS_JUMP;
        s_d.jump_addr[7:0] = prog_data_i;
        s_d.jump = 1'b1;
      end
      default:
      begin
        s_d.int_st = rais_pkg::IS_IDLE;
      end
    endcase
    // events latch regardless of mask; set wins over clears
    s_d.req[4:0] = s_d.req[4:0] | evt;
    // any reset abandons an interrupt sequence
    if (s_d.rst_st != rais_pkg::RS_RUN)
    begin
      s_d.int_st = rais_pkg::IS_IDLE;
      s_d.push_v = 1'b0;
      s_d.vec_rd = 1'b0;
      s_d.jump = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
      s_q.rst_st <= rais_pkg::RS_POR;
      s_q.pin_drive <= 1'b1;
      s_q.core_rst <= 1'b1;
      s_q.ds_n <= 1'b0;
      s_q.as_n <= 1'b1;
      s_q.cause <= rais_pkg::RST_CAUSE;
      s_q.req <= rais_pkg::RST_REQ;
      s_q.mask <= rais_pkg::RST_MASK;
      s_q.prio <= rais_pkg::RST_PRIO;
      s_q.flags <= rais_pkg::RST_FLAGS;
      s_q.stop_recovery_select <= rais_pkg::RST_SMR;
      s_q.prev_p <= 3'h7;
      s_q.prev_src <= 8'hff;
      s_q.int_st <= rais_pkg::IS_IDLE;
    end
    else
      s_q <= s_d;
  end

  /////////////////////////////////////////////////////////////////////////////
  assign prdata_o = {24'h000000, s_q.rdata};
  assign pready_o = s_q.pready;
  assign pslverr_o = s_q.pslverr;
  // open drain: only ever pulls low
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe_n_o = !s_q.pin_drive;
  assign reset_pullup_en_o = 1'b1;
  assign core_reset_o = s_q.core_rst;
  assign data_strobe_n_o = s_q.ds_n;
  assign address_strobe_n_o = s_q.as_n;
  assign fetch_start_o = s_q.fetch;
  assign fetch_addr_o = rais_pkg::RESET_VECTOR;
  assign push_valid_o = s_q.push_v;
  assign push_data_o = s_q.push_d;
  assign vec_rd_o = s_q.vec_rd;
  assign vec_addr_o = s_q.vec_addr;
  assign jump_o = s_q.jump;
  assign jump_addr_o = s_q.jump_addr;

  /////////////////////////////////////////////////////////////////////////////
  chk_filter_accept: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s_q.rst_st == rais_pkg::RS_RUN && !reset_pin_i && !stop_recovery_i)[*4] |-> ##2 core_reset_o)
    else $error("four low samples did not start reset");
  chk_filter_short: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(s_q.rst_st == rais_pkg::RS_HOLD) && $past(s_q.rst_st) == rais_pkg::RS_RUN &&
    $past(!stop_recovery_i && !low_voltage_i) |-> $past(s_q.low_cnt) == 3'h4)
    else $error("reset entered without full filter count");
  chk_hold_release: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(core_reset_o) |-> $past(s_q.cnt) == HOLD_LAST && $past(reset_pin_i))
    else $error("internal reset released early");
  chk_strobe_reset: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    core_reset_o && $past(core_reset_o) && !$past(rst_i) |->
    !data_strobe_n_o && address_strobe_n_o != $past(address_strobe_n_o))
    else $error("strobes wrong during reset");
  chk_fetch_delay: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(core_reset_o) |-> ##[5:10] (fetch_start_o && fetch_addr_o == 16'h000c))
    else $error("fetch did not start in window");
  chk_por_drive: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    por_i || wdt_timeout_i |=> (!reset_pin_oe_n_o && core_reset_o)[*8])
    else $error("reset pin not driven after power-on");
  chk_int_abort: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    core_reset_o |-> s_q.int_st == rais_pkg::IS_IDLE && !push_valid_o && !jump_o)
    else $error("interrupt sequence runs under reset");
  chk_grant_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    grant |=> !s_q.mask[rais_pkg::MASK_GLOBAL] && (!s_q.req[s_q.win] || $past(evt[win_c])))
    else $error("grant left request or enable set");
  chk_event_latch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    |evt |=> (s_q.req[4:0] & $past(evt)) == $past(evt))
    else $error("event lost from request register");
  chk_grant_enabled: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(push_valid_o) |-> $past(s_q.mask[rais_pkg::MASK_GLOBAL]) && $past(s_q.mask[win_c]))
    else $error("masked request granted");
  chk_push_order: assert property (@(posedge sys_clk_i) disable iff (rst_i || core_reset_o)
    $rose(push_valid_o) |-> push_valid_o[*3] ##1 (!push_valid_o && vec_rd_o) ##2 jump_o)
    else $error("interrupt cycle out of order");
endmodule
`default_nettype wire

// [tb/rais_rst_partner.sv]
// external reset circuit model sharing the open-drain reset line
`timescale 1ns/10ps
`default_nettype none
module rais_rst_partner (
  input wire logic sys_clk_i,
  input wire logic pull_i,
  input wire logic dev_oe_n_i,
  input wire logic dev_pin_i,
  input wire logic pullup_en_i,
  output logic pin_o
);
  logic last_q = 1'h1;
  logic low;
  // open-drain pull only
  // never driven high, so it cannot fight the device pulling low
  assign low = pull_i | (!dev_oe_n_i & !dev_pin_i);
  assign pin_o = low ? 1'h0 : (pullup_en_i ? 1'h1 : !last_q);
  always @(posedge sys_clk_i) last_q <= pin_o;
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the reset and interrupt sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int POR_N = 24;
  localparam logic [9:0] A_MASK = rais_pkg::ADDR_MASK;
  localparam logic [9:0] A_REQ = rais_pkg::ADDR_REQ;
  localparam logic [9:0] A_CAU = rais_pkg::ADDR_RST_CAUSE;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic pen = 1'h0;
  logic pwr = 1'h0;
  logic [9:0] padr = 10'h000;
  logic [31:0] pwd = 32'h0;
  logic [3:0] cz = 4'h0;
  logic [6:0] ev = 7'h07;
  logic an = 1'h0;
  logic pull = 1'h0;
  logic [7:0] src = 8'hff;
  logic [15:0] pc = 16'h0000;
  logic [31:0] lf = 32'h81c68495;
  logic [31:0] prd, r;
  logic rdy, err, e, pin, pin_o, oe_n, pu, core, ds_n, as_n, fst, vrd, pv, jmp;
  logic [15:0] fad, vad, jad;
  logic [7:0] pd, pgd, flg;
  logic [7:0] vt [16];
  int kt [8] = '{0, 1, 2, 3, 4, 2, 0, 1};
  int bt [7] = '{1, 2, 0, 3, 4, 5, 6};
  logic [7:0] md [3] = '{8'h40, 8'hc0, 8'h80};
  logic [7:0] fe [3] = '{8'h00, 8'h04, 8'h01};
  logic [7:0] re [3] = '{8'h01, 8'h04, 8'h00};
  int ln [3] = '{1, 0, 1};
  int pr [3] = '{2, 4, 7};
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int hi, gap, w, p;

  rais_sequencer #(.POR_CYCLES(POR_N)) DUT (
    .sys_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr),
    .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err), .por_i(cz[0]), .wdt_timeout_i(cz[1]),
    .stop_recovery_i(cz[2]), .low_voltage_i(cz[3]), .reset_pin_i(pin), .reset_pin_o(pin_o),
    .reset_pin_oe_n_o(oe_n), .reset_pullup_en_o(pu), .core_reset_o(core), .data_strobe_n_o(ds_n),
    .address_strobe_n_o(as_n), .fetch_start_o(fst), .fetch_addr_o(fad), .port3_line1_i(ev[0]),
    .port3_line2_i(ev[1]), .port3_line3_i(ev[2]), .timer0_evt_i(ev[3]), .timer1_evt_i(ev[4]),
    .comparator_input_one_evt_i(ev[5]), .comparator_input_two_evt_i(ev[6]), .analog_mode_i(an),
    .stop_recovery_src_i(src), .pc_i(pc), .push_valid_o(pv), .push_data_o(pd), .vec_rd_o(vrd),
    .vec_addr_o(vad), .prog_data_i(pgd), .jump_o(jmp), .jump_addr_o(jad));
  rais_rst_partner P (.sys_clk_i(clk), .pull_i(pull), .dev_oe_n_i(oe_n), .dev_pin_i(pin_o),
    .pullup_en_i(pu), .pin_o(pin));
  // program memory answers combinationally in the vector read cycle
  assign pgd = vt[vad[3:0]];

  initial
  begin
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      close_out();
    end
  end

  ////////////////////////////////////////
  task close_out();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input string nm, input logic [32:0] s, input logic [32:0] x);
    checks++;
    if (s !== x)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, x, s);
    end
  endtask

  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic int win(int q, int s);
    if (s > 4)
      s = 0;
    for (int i = 0; i < 5; i++)
      if (q[(s + i) % 5])
        return (s + i) % 5;
    return 0;
  endfunction

  task apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwr <= wr;
    padr <= a;
    pwd <= {lf[23:0], d};
    @(posedge clk);
    pen <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rdy !== 1'h1 && n < 20);
    r = prd;
    e = err;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask

  task rchk(input string nm, input logic [9:0] a, input logic [7:0] x);
    apb(1'h0, a, 8'h00);
    chk(nm, r, {24'h0, x});
  endtask

  // waits out one internal reset, watching the strobes and the fetch
  task rseq();
    int n;
    logic pa, pcr;
    n = 0;
    while (core !== 1'h1 && n < 12)
    begin
      @(negedge clk);
      n++;
    end
    hi = 0;
    pcr = 1'h0;
    while (core === 1'h1 && hi < 9000)
    begin
      pa = as_n;
      @(negedge clk);
      hi++;
      if (core === 1'h1 && pcr === 1'h1)
      begin
        chk("data strobe", ds_n, 1'h0);
        chk("addr strobe", as_n, !pa);
      end
      pcr = core;
    end
    gap = 0;
    while (fst !== 1'h1 && gap < 20)
    begin
      @(negedge clk);
      gap++;
    end
    chk("fetch gap", gap >= 5 && gap <= 10, 1'h1);
    chk("fetch addr", fad, 16'h000c);
  endtask

  task pls(int n);
    @(posedge clk);
    pull <= 1'h1;
    repeat (n) @(posedge clk);
    pull <= 1'h0;
  endtask

  task fire(int s);
    @(posedge clk);
    if (s == 7)
      src <= 8'hfe;
    else
      ev <= ev ^ (7'h01 << bt[s]);
    repeat (2) @(posedge clk);
    ev <= 7'h07;
    src <= 8'hff;
    repeat (3) @(posedge clk);
  endtask

  task sv(int k);
    int n;
    n = 0;
    while (pv !== 1'h1 && n < 30)
    begin
      @(negedge clk);
      n++;
    end
    chk("push lo", {pv, pd}, {1'h1, pc[7:0]});
    @(negedge clk);
    chk("push hi", {pv, pd}, {1'h1, pc[15:8]});
    @(negedge clk);
    chk("push flags", {pv, pd}, {1'h1, flg});
    @(negedge clk);
    chk("vector hi", {vrd, vad}, {1'h1, 16'(2 * k)});
    @(negedge clk);
    chk("vector lo", {vrd, vad}, {1'h1, 16'(2 * k + 1)});
    @(negedge clk);
    chk("jump", {jmp, jad}, {1'h1, vt[2 * k], vt[2 * k + 1]});
  endtask

  ////////////////////////////////////////
  initial
  begin
    for (int i = 0; i < 16; i++)
    begin
      lf = nx(lf);
      vt[i] = lf[7:0];
    end
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    chk("pin driven", {oe_n, pin, pu, pin_o}, 4'h2);
    fork
      rseq();
      begin
        rchk("cause", A_CAU, rais_pkg::RST_CAUSE);
        rchk("req", A_REQ, rais_pkg::RST_REQ);
        rchk("mask", A_MASK, rais_pkg::RST_MASK);
        rchk("prio", rais_pkg::ADDR_PRIO, rais_pkg::RST_PRIO);
        rchk("smr", rais_pkg::ADDR_SMR_SEL, rais_pkg::RST_SMR);
        apb(1'h0, 10'h000, 8'h00);
        chk("unmapped", {e, r}, {1'h1, 32'h0});
      end
    join
    chk("por hold", hi >= POR_N + 18, 1'h1);
    apb(1'h1, A_CAU, 8'h1f);
    for (int n = 1; n < 4; n++)
    begin
      pls(n);
      repeat (8) @(negedge clk);
      chk("glitch", core, 1'h0);
    end
    fork
      pls(4);
      rseq();
    join
    chk("ext hold", hi >= 18 && hi <= 20, 1'h1);
    fork
      pls(40);
      rseq();
    join
    chk("long hold", hi >= 33 && hi <= 38, 1'h1);
    rchk("ext cause", A_CAU, 8'h10);
    apb(1'h1, A_CAU, 8'h1f);
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clk);
      cz <= 4'h1 << c;
      @(posedge clk);
      cz <= 4'h0;
      repeat (3) @(negedge clk);
      chk("cause pin", oe_n, c > 1);
      rseq();
      rchk("cause", A_CAU, 8'h01 << c);
      apb(1'h1, A_CAU, 8'h1f);
    end
    ////////////////////////////////////////
    lf = nx(lf);
    pc <= lf[15:0];
    flg = lf[23:16];
    apb(1'h1, rais_pkg::ADDR_FLAGS, flg);
    rchk("flags", rais_pkg::ADDR_FLAGS, flg);
    for (int s = 0; s < 8; s++)
    begin
      an <= s == 7;
      apb(1'h1, rais_pkg::ADDR_SMR_SEL, 8'h01);
      apb(1'h1, A_MASK, 8'h1f);
      fire(s);
      rchk("pending", A_REQ, 8'h01 << kt[s]);
      apb(1'h1, A_MASK, 8'h9f ^ (8'h01 << kt[s]));
      repeat (6) @(negedge clk);
      chk("masked", pv, 1'h0);
      apb(1'h1, A_MASK, 8'h9f);
      sv(kt[s]);
      rchk("cleared", A_REQ, 8'h00);
      rchk("global off", A_MASK, 8'h1f);
    end
    for (int m = 0; m < 3; m++)
    begin
      apb(1'h1, A_REQ, md[m]);
      @(posedge clk);
      ev[ln[m]] <= 1'h0;
      repeat (3) @(posedge clk);
      rchk("fall", A_REQ, md[m] | fe[m]);
      apb(1'h1, A_REQ, md[m]);
      ev[ln[m]] <= 1'h1;
      repeat (3) @(posedge clk);
      rchk("rise", A_REQ, md[m] | re[m]);
    end
    apb(1'h1, A_REQ, 8'h00);
    for (int q = 0; q < 3; q++)
    begin
      p = 10;
      fire(3);
      fire(1);
      apb(1'h1, rais_pkg::ADDR_PRIO, pr[q][7:0]);
      for (int j = 0; j < 2; j++)
      begin
        w = win(p, pr[q]);
        apb(1'h1, A_MASK, 8'h9f);
        sv(w);
        p = p & ~(1 << w);
      end
    end
    close_out();
  end
endmodule
`default_nettype wire
